// File: hdl/vcfc_top.v
// Notes on behaviour
// - receive channel goes to standby after five or more frames of low receive sync.
// - transmit channel goes to standby after five or more frames of low transmit sync.
// - either sync held high five or more frames enters production test mode.
// - transmit and receive syncs are watched independently with identical logic.
// - coding select low means linear words, high means companded words.
// - companded coding follows the mu-law or a-law variant chosen.
// - microphone mute low sends the zero code in every transmit slot.
// - earphone mute low disables the earphone amplifier.
// - power-down low puts the device in its low-power state.
// - at fixed rate the strobe pin is an active-low open-drain slot strobe.
// - at variable rate the strobe pin is the host-driven transmit bit clock.
// - receive clock pin tied high selects fixed rate, else it is the clock.
// - receive data sampled on falling edges of the receive data clock.
// - transmit data shifted out on rising edges of the transmit data clock.
// - companded words are 8 bits; linear words 13 data plus 3 gain bits.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`default_nettype none
`include "vcfc_regs.vh"
module vcfc_top (
  input wire core_clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire master_clk,
  input wire rx_bit_clock_rate_sel,
  input wire rx_frame_sync,
  input wire tx_frame_sync,
  input wire rx_data_in,
  input wire coding_select,
  input wire mic_mute_n,
  input wire earphone_mute_n,
  input wire power_down_n,
  input wire tx_strobe_or_clock_in,
  output reg tx_strobe_or_clock_out,
  output reg tx_strobe_or_clock_oe_n,
  output reg tx_data_out,
  output reg earphone_amp_en,
  output reg low_power,
  output wire rx_standby,
  output wire tx_standby,
  output reg test_mode
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  // bit order: mclk, rx_bit_clock_rate_sel, fsr, fsx, din, coding, mic_mute_n, earphone_mute_n, pdn, tx_bit_clock
  reg [9:0] pin_meta_reg;
  reg [9:0] pin_sync_reg;
  reg [9:0] pin_prev_reg;
  wire [9:0] pin_raw;
  assign pin_raw = {tx_strobe_or_clock_in, power_down_n, earphone_mute_n, mic_mute_n,
    coding_select, rx_data_in, tx_frame_sync, rx_frame_sync, rx_bit_clock_rate_sel,
    master_clk};

  // reset to the pins' idle levels: a tied-high rate pin or a pulled-up
  // strobe pin must not show a false edge right after reset
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_reg <= `VCFC_PIN_IDLE;
      pin_sync_reg <= `VCFC_PIN_IDLE;
      pin_prev_reg <= `VCFC_PIN_IDLE;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  wire [9:0] pin_rise;
  wire [9:0] pin_fall;
  assign pin_rise = pin_sync_reg & ~pin_prev_reg;
  assign pin_fall = ~pin_sync_reg & pin_prev_reg;
  wire companded;
  assign companded = pin_sync_reg[5];

  // ****************************************
  // fixed or variable rate detection
  // ****************************************
  // a tied-high pin never toggles; a live clock toggles well inside the window
  reg fixed_rate_reg;
  reg [7:0] quiet_cnt_reg;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fixed_rate_reg <= 1'b1;
      quiet_cnt_reg <= 8'h00;
    end else if (pin_rise[1] || pin_fall[1]) begin
      quiet_cnt_reg <= 8'h00;
      fixed_rate_reg <= 1'b0;
    end else if ({24'h000000, quiet_cnt_reg} < `VCFC_FIXED_DET_CYC) begin
      quiet_cnt_reg <= quiet_cnt_reg + 8'h01;
    end else begin
      fixed_rate_reg <= pin_sync_reg[1];
    end
  end

  wire rx_clk_fall;
  wire tx_clk_rise;
  assign rx_clk_fall = fixed_rate_reg ? pin_fall[0] : pin_fall[1];
  assign tx_clk_rise = fixed_rate_reg ? pin_rise[0] : pin_rise[9];

  // ****************************************
  // frame watchers, one per channel
  // ****************************************
  wire rx_held;
  wire tx_held;
  vcfc_frame_mon u_rx_mon (
    .core_clk(core_clk),
    .rstn(rstn),
    .mclk_rise(pin_rise[0]),
    .sync_lvl(pin_sync_reg[2]),
    .sync_rise(pin_rise[2]),
    .standby_reg(rx_standby),
    .held_high_reg(rx_held)
  );
  vcfc_frame_mon u_tx_mon (
    .core_clk(core_clk),
    .rstn(rstn),
    .mclk_rise(pin_rise[0]),
    .sync_lvl(pin_sync_reg[3]),
    .sync_rise(pin_rise[3]),
    .standby_reg(tx_standby),
    .held_high_reg(tx_held)
  );

  // ****************************************
  // static controls
  // ****************************************
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      test_mode <= 1'b0;
      earphone_amp_en <= 1'b0;
      low_power <= 1'b0;
    end else begin
      test_mode <= rx_held | tx_held;
      earphone_amp_en <= pin_sync_reg[7] & pin_sync_reg[8];
      low_power <= ~pin_sync_reg[8];
    end
  end

  // ****************************************
  // registers written by software
  // ****************************************
  reg [3:0] ctrl_reg;
  reg [15:0] tx_word_reg;
  reg [15:0] rx_word_reg;
  reg rx_ready_reg;
  wire wr_take;
  wire rd_ack_clear;
  assign wr_take = psel & penable & pready & pwrite;
  assign rd_ack_clear = wr_take && paddr == `VCFC_ADDR_STATUS && pwdata[`VCFC_ST_RX_READY];
  wire alaw;
  wire [2:0] gain_bits;
  assign alaw = ctrl_reg[`VCFC_CTRL_ALAW];
  assign gain_bits = ctrl_reg[`VCFC_CTRL_GAIN_HI:`VCFC_CTRL_GAIN_LO];

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= `VCFC_CTRL_RESET;
      tx_word_reg <= `VCFC_TX_WORD_RESET;
    end else if (wr_take) begin
      if (paddr == `VCFC_ADDR_CTRL) begin
        ctrl_reg <= pwdata[3:0];
      end
      if (paddr == `VCFC_ADDR_TX_WORD) begin
        tx_word_reg <= pwdata[15:0];
      end
    end
  end

  // ****************************************
  // receive shifter
  // ****************************************
  reg [4:0] rx_left_reg;
  reg [15:0] rx_shift_reg;
  wire rx_done;
  assign rx_done = rx_clk_fall && rx_left_reg == 5'h01;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_left_reg <= 5'h00;
      rx_shift_reg <= 16'h0000;
      rx_word_reg <= 16'h0000;
      rx_ready_reg <= 1'b0;
    end else begin
      if (pin_rise[2] && !low_power) begin
        rx_left_reg <= companded ? `VCFC_LEN_COMPANDED : `VCFC_LEN_LINEAR;
      end else if (rx_clk_fall && rx_left_reg != 5'h00) begin
        rx_left_reg <= rx_left_reg - 5'h01;
        rx_shift_reg <= {rx_shift_reg[14:0], pin_sync_reg[4]};
      end
      if (rx_done) begin
        rx_word_reg <= companded ? {8'h00, rx_shift_reg[6:0], pin_sync_reg[4]} :
          {rx_shift_reg[14:0], pin_sync_reg[4]};
      end
      // a word landing in the same cycle as the clear keeps the flag set
      if (rx_done) begin
        rx_ready_reg <= 1'b1;
      end else if (rd_ack_clear) begin
        rx_ready_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // transmit shifter and slot strobe
  // ****************************************
  reg [4:0] tx_left_reg;
  reg [15:0] tx_shift_reg;
  reg [15:0] tx_load;
  always @* begin
    if (companded) begin
      if (!pin_sync_reg[6]) begin
        tx_load = {alaw ? `VCFC_ZERO_ALAW : `VCFC_ZERO_MULAW, 8'h00};
      end else begin
        tx_load = {tx_word_reg[7:0], 8'h00};
      end
    end else begin
      if (!pin_sync_reg[6]) begin
        tx_load = {`VCFC_ZERO_LINEAR, gain_bits};
      end else begin
        tx_load = {tx_word_reg[15:3], gain_bits};
      end
    end
  end

  // the clock rise that arrives with the sync rise is spent loading the slot,
  // so the first bit leaves on the following rise
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_left_reg <= 5'h00;
      tx_shift_reg <= 16'h0000;
      tx_data_out <= 1'b0;
      tx_strobe_or_clock_out <= 1'b1;
      tx_strobe_or_clock_oe_n <= 1'b1;
    end else begin
      if (pin_rise[3] && !low_power) begin
        tx_left_reg <= companded ? `VCFC_LEN_COMPANDED : `VCFC_LEN_LINEAR;
        tx_shift_reg <= tx_load;
      end else if (tx_clk_rise && tx_left_reg != 5'h00) begin
        tx_left_reg <= tx_left_reg - 5'h01;
        tx_data_out <= tx_shift_reg[15];
        tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
      end
      // open drain: only ever pulls low, released otherwise
      tx_strobe_or_clock_out <= 1'b0;
      if (fixed_rate_reg && tx_left_reg != 5'h00) begin
        tx_strobe_or_clock_oe_n <= 1'b0;
      end else begin
        tx_strobe_or_clock_oe_n <= 1'b1;
      end
    end
  end

  // ****************************************
  // apb slave, one wait state per access
  // ****************************************
  // pready drops after every pulse, so back-to-back accesses each wait one cycle
  reg [31:0] rd_mux;
  reg addr_ok;
  always @* begin
    rd_mux = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
      `VCFC_ADDR_CTRL: rd_mux[3:0] = ctrl_reg;
      `VCFC_ADDR_TX_WORD: rd_mux[15:0] = tx_word_reg;
      `VCFC_ADDR_RX_WORD: rd_mux[15:0] = rx_word_reg;
      `VCFC_ADDR_STATUS: begin
        rd_mux[`VCFC_ST_RX_STANDBY] = rx_standby;
        rd_mux[`VCFC_ST_TX_STANDBY] = tx_standby;
        rd_mux[`VCFC_ST_TEST_MODE] = test_mode;
        rd_mux[`VCFC_ST_FIXED_RATE] = fixed_rate_reg;
        rd_mux[`VCFC_ST_LOW_POWER] = low_power;
        rd_mux[`VCFC_ST_RX_READY] = rx_ready_reg;
        rd_mux[`VCFC_ST_COMPANDED] = companded;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= ~addr_ok;
      prdata <= pwrite ? 32'h00000000 : rd_mux;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end
endmodule // vcfc_top
`default_nettype wire

// File: hdl/vcfc_regs.vh
`ifndef VCFC_REGS_VH
`define VCFC_REGS_VH
// ****************************************
// register map, byte addresses on apb
// ****************************************
`define VCFC_ADDR_CTRL 8'h00
`define VCFC_ADDR_TX_WORD 8'h04
`define VCFC_ADDR_RX_WORD 8'h08
`define VCFC_ADDR_STATUS 8'h0c
// ****************************************
// field positions
// ****************************************
`define VCFC_CTRL_ALAW 0
`define VCFC_CTRL_GAIN_LO 1
`define VCFC_CTRL_GAIN_HI 3
`define VCFC_ST_RX_STANDBY 0
`define VCFC_ST_TX_STANDBY 1
`define VCFC_ST_TEST_MODE 2
`define VCFC_ST_FIXED_RATE 3
`define VCFC_ST_LOW_POWER 4
`define VCFC_ST_RX_READY 5
`define VCFC_ST_COMPANDED 6
// ****************************************
// reset values
// ****************************************
`define VCFC_CTRL_RESET 4'h0
`define VCFC_TX_WORD_RESET 16'h0000
`define VCFC_PIN_IDLE 10'h3c2
// ****************************************
// word formats and zero codes
// ****************************************
`define VCFC_LEN_COMPANDED 5'h08
`define VCFC_LEN_LINEAR 5'h10
`define VCFC_ZERO_MULAW 8'hff
`define VCFC_ZERO_ALAW 8'hd5
`define VCFC_ZERO_LINEAR 13'h0000
// ****************************************
// timing
// ****************************************
`define VCFC_CLK_MHZ 40
`define VCFC_FIXED_DET_NS 1600
`define VCFC_FIXED_DET_CYC ((`VCFC_FIXED_DET_NS * `VCFC_CLK_MHZ + 999) / 1000)
`define VCFC_IDLE_FRAMES 5
`define VCFC_DEF_FRAME_MCLK 16'h0100
`endif

// File: hdl/vcfc_frame_mon.v
`default_nettype none
`include "vcfc_regs.vh"
// ****************************************
// per-channel frame sync watcher
// ****************************************
module vcfc_frame_mon (
  input wire core_clk,
  input wire rstn,
  input wire mclk_rise,
  input wire sync_lvl,
  input wire sync_rise,
  output reg standby_reg,
  output reg held_high_reg
);
  reg [15:0] period_reg;
  reg [15:0] since_rise_reg;
  reg [19:0] low_run_reg;
  reg [19:0] high_run_reg;
  wire [19:0] limit;
  // frame length is learnt from the spacing of sync rises, in master clocks
  assign limit = {4'h0, period_reg} * 20'h00005;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      period_reg <= `VCFC_DEF_FRAME_MCLK;
      since_rise_reg <= 16'h0000;
      low_run_reg <= 20'h00000;
      high_run_reg <= 20'h00000;
      standby_reg <= 1'b1;
      held_high_reg <= 1'b0;
    end else begin
      if (sync_rise) begin
        if (since_rise_reg != 16'h0000) begin
          period_reg <= since_rise_reg;
        end
        since_rise_reg <= 16'h0000;
      end else if (mclk_rise && since_rise_reg != 16'hffff) begin
        since_rise_reg <= since_rise_reg + 16'h0001;
      end
      if (sync_lvl) begin
        low_run_reg <= 20'h00000;
      end else if (mclk_rise && low_run_reg != 20'hfffff) begin
        low_run_reg <= low_run_reg + 20'h00001;
      end
      if (!sync_lvl) begin
        high_run_reg <= 20'h00000;
      end else if (mclk_rise && high_run_reg != 20'hfffff) begin
        high_run_reg <= high_run_reg + 20'h00001;
      end
      if (sync_rise) begin
        standby_reg <= 1'b0;
      end else if (low_run_reg >= limit) begin
        standby_reg <= 1'b1;
      end
      held_high_reg <= sync_lvl && (high_run_reg >= limit);
    end
  end
endmodule // vcfc_frame_mon
`default_nettype wire

// File: bench/vcfc_top_asserts.sv
`default_nettype none
// ****
// pin and frame checks
// ****
module vcfc_top_asserts (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_frame_sync,
  input wire logic tx_frame_sync,
  input wire logic power_down_n,
  input wire logic earphone_mute_n,
  input wire logic earphone_amp_en,
  input wire logic low_power,
  input wire logic tx_strobe_or_clock_out,
  input wire logic tx_strobe_or_clock_oe_n,
  input wire logic rx_standby,
  input wire logic tx_standby,
  input wire logic test_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  // bounds allow five frames plus sync latency: the 256-clock reset frame for standby, 32-clock frames for test mode
  localparam int STBY_CYC = 10400;
  localparam int HI_CYC = 1600;
  logic [31:0] rx_lo_cnt;
  logic [31:0] tx_hi_cnt;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_lo_cnt <= 32'h0;
      tx_hi_cnt <= 32'h0;
    end else begin
      rx_lo_cnt <= rx_frame_sync ? 32'h0 : rx_lo_cnt + 32'h1;
      tx_hi_cnt <= tx_frame_sync ? tx_hi_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_LP_ON: assert property (!power_down_n [*5] |-> low_power)
    else $error("low power not entered");
  AST_LP_OFF: assert property (power_down_n [*5] |-> !low_power)
    else $error("low power stuck");
  AST_EAR_OFF: assert property (!earphone_mute_n [*5] |-> !earphone_amp_en)
    else $error("earphone amp on while muted");
  AST_EAR_ON: assert property ((earphone_mute_n && power_down_n) [*5] |-> earphone_amp_en)
    else $error("earphone amp off");
  AST_OD: assert property (!tx_strobe_or_clock_oe_n |-> !tx_strobe_or_clock_out)
    else $error("strobe driven high");
  AST_RX_STBY: assert property (rx_lo_cnt == STBY_CYC |-> rx_standby)
    else $error("receive standby missing");
  AST_RX_WAKE: assert property ($rose(rx_frame_sync) && power_down_n |-> ##[1:8] !rx_standby)
    else $error("receive standby not left");
  AST_TX_WAKE: assert property ($rose(tx_frame_sync) && power_down_n |-> ##[1:8] !tx_standby)
    else $error("transmit standby not left");
  AST_TEST: assert property (tx_hi_cnt == HI_CYC |-> test_mode)
    else $error("test mode missing");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
  cover property ($rose(rx_standby));
  cover property ($rose(test_mode));
  cover property (pslverr);
endmodule // vcfc_top_asserts
bind vcfc_top vcfc_top_asserts u_vcfc_top_asserts (.core_clk, .rstn, .pready, .pslverr,
  .rx_frame_sync, .tx_frame_sync, .power_down_n, .earphone_mute_n, .earphone_amp_en,
  .low_power, .tx_strobe_or_clock_out, .tx_strobe_or_clock_oe_n, .rx_standby, .tx_standby,
  .test_mode);
`default_nettype wire

// File: bench/vcfc_dsp_model.sv
`default_nettype none
// ****
// host side: master clock, syncs, serial data
// ****
module vcfc_dsp_model #(
  parameter int FRAME = 32
) (
  input wire logic var_rate,
  input wire logic tx_data_out,
  output logic master_clk,
  output logic rx_bit_clock_rate_sel,
  output logic rx_frame_sync,
  output logic tx_frame_sync,
  output logic rx_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // 7 ns offset keeps the master clock out of phase with core_clk
  initial begin
    master_clk = 1'b0;
    rx_frame_sync = 1'b0;
    tx_frame_sync = 1'b0;
    rx_data_in = 1'b0;
    #7;
    forever #100 master_clk = ~master_clk;
  end
  assign rx_bit_clock_rate_sel = var_rate ? master_clk : 1'b1;
  // data moves on rises so falls see it settled; idle line toggles
  task automatic frame(input logic [15:0] rxw, input int nb, input logic rx_on,
                       input logic tx_on, input int hi, output logic [15:0] txw);
    int i;
    txw = 16'h0;
    for (i = 0; i < FRAME; i++) begin
      @(posedge master_clk);
      // first bit leaves on the rise after the sync rise, so it is seen one rise later
      if (i > 1 && i <= nb + 1) txw = {txw[14:0], tx_data_out};
      rx_frame_sync <= rx_on && i < hi;
      tx_frame_sync <= tx_on && i < hi;
      rx_data_in <= i < nb ? rxw[nb - 1 - i] : ~rx_data_in;
    end
  endtask
endmodule // vcfc_dsp_model
`default_nettype wire

// File: bench/test_voice_codec_frame_control.sv
`default_nettype none
`include "vcfc_regs.vh"
// ****
// bench top
// ****
module test_voice_codec_frame_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, master_clk, rx_bit_clock_rate_sel, rx_frame_sync;
  logic tx_frame_sync, rx_data_in, tx_strobe_or_clock_in, var_rate = 1'b0;
  logic coding_select = 1'b1, mic_mute_n = 1'b1, earphone_mute_n = 1'b1;
  logic power_down_n = 1'b1, tx_strobe_or_clock_out, tx_strobe_or_clock_oe_n;
  logic tx_data_out, earphone_amp_en, low_power, rx_standby, tx_standby, test_mode;
  logic [15:0] txw, word, exp;
  logic [3:0] ctrl;
  int miscompares = 0, comparisons = 0, seed = 21, lo_cnt = 0;
  always #12.5 core_clk = ~core_clk;
  // open drain with pull-up; the host clocks the pin at variable rate
  assign tx_strobe_or_clock_in = !tx_strobe_or_clock_oe_n ? tx_strobe_or_clock_out :
                                 var_rate ? master_clk : 1'b1;
  always @(posedge core_clk) lo_cnt <= lo_cnt + int'(tx_strobe_or_clock_oe_n === 1'b0);
  vcfc_top u_vcfc_top (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .master_clk, .rx_bit_clock_rate_sel, .rx_frame_sync,
    .tx_frame_sync, .rx_data_in, .coding_select, .mic_mute_n, .earphone_mute_n,
    .power_down_n, .tx_strobe_or_clock_in, .tx_strobe_or_clock_out,
    .tx_strobe_or_clock_oe_n, .tx_data_out, .earphone_amp_en, .low_power, .rx_standby,
    .tx_standby, .test_mode);
  vcfc_dsp_model u_vcfc_dsp_model (.var_rate, .tx_data_out, .master_clk,
    .rx_bit_clock_rate_sel, .rx_frame_sync, .tx_frame_sync, .rx_data_in);
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic chk_pin(input logic got, input logic want);
    chk({31'h0, got}, {31'h0, want});
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk(rd, want);
  endtask
  task automatic fr(input logic rx_on, input logic tx_on, input int hi);
    u_vcfc_dsp_model.frame(word, 8, rx_on, tx_on, hi, txw);
  endtask
  task automatic xfer(input int nb);
    int lo0;
    lo0 = lo_cnt;
    u_vcfc_dsp_model.frame(word, nb, 1'b1, 1'b1, var_rate ? nb : 1, txw);
    chk_pin((lo_cnt - lo0) inside {[nb * 8 - 3 : nb * 8 + 3]}, !var_rate);
    rdchk(8'h08, nb == 16 ? {16'h0, word} : {24'h0, word[7:0]});
    apb(1'b0, 8'h0c, 32'h0);
    chk_pin(rd[5], 1'b1);
    apb(1'b1, 8'h0c, 32'h20);
  endtask
  task automatic test_done;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #1ms;
    miscompares++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (80) @(posedge core_clk);
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'h0);
    rdchk(8'h0c, 32'h4b);
    apb(1'b1, 8'h10, 32'h1);
    chk_pin(err, 1'b1);
    for (int k = 0; k < 4; k++) begin
      power_down_n <= k[0];
      earphone_mute_n <= k[1];
      repeat (5) @(posedge core_clk);
      chk_pin(low_power, !k[0]);
      chk_pin(earphone_amp_en, k[0] && k[1]);
    end
    for (int m = 0; m < 8; m++) begin
      word = 16'($random(seed));
      ctrl = 4'($random(seed));
      ctrl[0] = m[0];
      apb(1'b1, 8'h00, {28'h0, ctrl});
      apb(1'b1, 8'h04, {16'h0, word});
      coding_select <= !m[2];
      mic_mute_n <= !m[1];
      repeat (4) @(posedge core_clk);
      xfer(m[2] ? 16 : 8);
      if (m[2]) exp = m[1] ? {`VCFC_ZERO_LINEAR, ctrl[3:1]} : {word[15:3], ctrl[3:1]};
      else exp = m[1] ? (m[0] ? `VCFC_ZERO_ALAW : `VCFC_ZERO_MULAW) : word[7:0];
      chk({16'h0, txw}, {16'h0, exp});
    end
    repeat (42) fr(1'b0, 1'b1, 1);
    chk_pin(rx_standby, 1'b1);
    chk_pin(tx_standby, 1'b0);
    repeat (2) fr(1'b1, 1'b1, 1);
    chk_pin(rx_standby, 1'b0);
    repeat (3) fr(1'b1, 1'b0, 1);
    chk_pin(tx_standby, 1'b0);
    repeat (4) fr(1'b1, 1'b0, 1);
    chk_pin(tx_standby, 1'b1);
    chk_pin(rx_standby, 1'b0);
    repeat (2) fr(1'b1, 1'b1, 1);
    chk_pin(tx_standby, 1'b0);
    repeat (8) fr(1'b0, 1'b1, 32);
    chk_pin(test_mode, 1'b1);
    repeat (2) fr(1'b1, 1'b1, 1);
    chk_pin(test_mode, 1'b0);
    coding_select <= 1'b1;
    mic_mute_n <= 1'b1;
    var_rate <= 1'b1;
    repeat (20) @(posedge core_clk);
    apb(1'b0, 8'h0c, 32'h0);
    chk_pin(rd[3], 1'b0);
    xfer(8);
    chk({16'h0, txw}, {24'h0, word[7:0]});
    test_done();
  end
endmodule // test_voice_codec_frame_control
`default_nettype wire
